// *** design/mio_motion_io.sv ***
// motion i/o top: limits, step/dir, encoder, adc, leds, restore
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module mio_motion_io #(
  parameter int unsigned SLOW_HALF_CYC = mio_pkg::LED_SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF_CYC = mio_pkg::LED_FAST_HALF_CYC
) (
  input  logic                        clock,
  input  logic                        srst,
  input  logic [mio_pkg::ADDR_W-1:0]  regAddr,
  input  logic [mio_pkg::DATA_W-1:0]  regWdata,
  input  logic                        regWr,
  input  logic                        regRd,
  output logic [mio_pkg::DATA_W-1:0]  regRdata,
  input  logic                        stopLeftStepIn,
  input  logic                        stopRightDirIn,
  input  logic                        analogHomeInput,
  input  logic                        generalInputAEnc,
  input  logic                        generalInputBEnc,
  output logic                        adcStart,
  input  logic [mio_pkg::ADC_W-1:0]   adcData,
  input  logic                        adcDone,
  output logic                        genPullupEn,
  output logic                        homePullupEn,
  output logic                        openDrainOutput,
  output logic                        openDrainOutputOeN,
  output logic                        padClkOut,
  output logic                        padClkOeN,
  input  logic                        padDioIn,
  output logic                        nvmRestoreReq,
  input  logic                        nvmRestoreDone,
  input  logic                        fwValid,
  input  logic                        fwUpdate,
  output logic                        drvStep,
  output logic                        drvDir,
  output logic [mio_pkg::DATA_W-1:0]  position,
  output logic                        greenLed,
  output logic                        redLed,
  output logic                        irq
);
  import mio_pkg::*;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // pin synchroniser
  mio_sync_if syncBus ();
  assign syncBus.rawIn = {padDioIn, generalInputBEnc, generalInputAEnc,
                          analogHomeInput, stopRightDirIn, stopLeftStepIn};
  mio_sync u_sync (
    .clock (clock),
    .srst  (srst),
    .bus   (syncBus)
  );

  logic leftIn;  // stop left or step, synchronised
  logic rightIn; // stop right or direction, synchronised
  logic homeIn;  // home level, synchronised
  logic encA;    // encoder channel a
  logic encB;    // encoder channel b
  logic padIn;   // programming pad sense
  assign leftIn  = syncBus.synced[SY_LEFT];
  assign rightIn = syncBus.synced[SY_RIGHT];
  assign homeIn  = syncBus.synced[SY_HOME];
  assign encA    = syncBus.synced[SY_ENCA];
  assign encB    = syncBus.synced[SY_ENCB];
  assign padIn   = syncBus.synced[SY_PAD];

  // register state
  logic [CTRL_W-1:0] ctrl_reg;      // control fields
  logic [DATA_W-1:0] position_reg;  // position in 1/256 steps
  logic [DATA_W-1:0] encCount_reg;  // encoder count
  logic [ADC_W-1:0]  adcResult_reg; // last conversion
  logic              adcBusy_reg;   // conversion running
  logic              adcStart_reg;  // start pulse to converter
  logic [IRQ_W-1:0]  irqStat_reg;   // sticky events
  logic [IRQ_W-1:0]  irqStat_next;  // events after this cycle
  logic [IRQ_W-1:0]  irqEn_reg;     // event enables
  logic              irq_reg;       // interrupt level
  logic [DATA_W-1:0] rdata_reg;     // read data, one cycle late
  mio_boot_t         boot_reg;      // power-on sequence state
  logic [7:0]        settle_reg;    // pad settle counter
  logic              restored_reg;  // defaults were restored

  // address decode
  logic wrCtrl, wrPos, wrEnc, wrAdc, wrMove, wrClr, wrEn;
  assign wrCtrl = regWr && regAddr == OFS_CTRL;
  assign wrPos  = regWr && regAddr == OFS_POS;
  assign wrEnc  = regWr && regAddr == OFS_ENC;
  assign wrAdc  = regWr && regAddr == OFS_ADC;
  assign wrMove = regWr && regAddr == OFS_MOVE;
  assign wrClr  = regWr && regAddr == OFS_IRQ_CLR;
  assign wrEn   = regWr && regAddr == OFS_IRQ_EN;

  logic ctrlDrv, ctrlInterp, ctrlEnc;
  assign ctrlDrv    = ctrl_reg[CB_DRV_MODE];
  assign ctrlInterp = ctrl_reg[CB_INTERP];
  assign ctrlEnc    = ctrl_reg[CB_ENC_EN];

  // control register; a pad short forces factory values
  always_ff @(posedge clock) begin
    if (srst || boot_reg == BOOT_RESTORE) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_reg <= regWdata[CTRL_W-1:0];
    end
  end

  // pull-up and open-drain pins follow control bits
  logic genPu_reg, homePu_reg, odOeN_reg;
  always_ff @(posedge clock) begin
    if (srst) begin
      genPu_reg  <= CTRL_RESET[CB_GEN_PU];
      homePu_reg <= CTRL_RESET[CB_HOME_PU];
      odOeN_reg  <= 1'b1;
    end else begin
      genPu_reg  <= ctrl_reg[CB_GEN_PU];
      homePu_reg <= ctrl_reg[CB_HOME_PU];
      odOeN_reg  <= !ctrl_reg[CB_OD_ON];
    end
  end

  // microstep size; codes above the maximum are clamped
  logic [MS_W-1:0]   msShift;
  logic [DATA_W-1:0] stepInc;
  assign msShift = (ctrl_reg[CB_MS_LSB +: MS_W] > MS_SHIFT_MAX) ?
                   MS_SHIFT_MAX : ctrl_reg[CB_MS_LSB +: MS_W];
  assign stepInc = DATA_W'(1) << msShift;

  // step sources and limit gating
  logic stepPrev_reg;       // last step level for edge detect
  logic [8:0] pend_reg;     // interpolator units still to move
  logic pendDir_reg;        // interpolator direction
  logic drvEdge, swStep, stepFire, stepDir;
  logic leftBlock, rightBlock, stepBlocked, stepOk, overrun, unitMove;
  assign drvEdge  = ctrlDrv && leftIn && !stepPrev_reg;
  assign swStep   = wrMove && !ctrlDrv && regWdata[MOVE_GO];
  assign stepFire = drvEdge || swStep;
  assign stepDir  = ctrlDrv ? rightIn : regWdata[MOVE_DIR];
  // in driver mode the limit pins carry step/dir, so no gating
  assign leftBlock   = ctrl_reg[CB_LEFT_EN] && !ctrlDrv && leftIn;
  assign rightBlock  = ctrl_reg[CB_RIGHT_EN] && !ctrlDrv && rightIn;
  assign stepBlocked = stepDir ? rightBlock : leftBlock;
  // the interpolator takes one step at a time; at the rated step
  // rate it always drains long before the next edge
  assign overrun  = stepFire && pend_reg != '0;
  assign stepOk   = stepFire && !stepBlocked && !overrun &&
                    boot_reg == BOOT_NORMAL;
  assign unitMove = pend_reg != '0 &&
                    !(pendDir_reg ? rightBlock : leftBlock);

  // step edge history
  always_ff @(posedge clock) begin
    if (srst) begin
      stepPrev_reg <= 1'b0;
    end else begin
      stepPrev_reg <= leftIn;
    end
  end

  // interpolator spreads one coarse step into unit moves
  always_ff @(posedge clock) begin
    if (srst) begin
      pend_reg    <= '0;
      pendDir_reg <= 1'b0;
    end else if (stepOk && ctrlInterp) begin
      pend_reg    <= stepInc[8:0];
      pendDir_reg <= stepDir;
    end else if (unitMove) begin
      pend_reg    <= pend_reg - 9'h001;
    end
  end

  // position counter; a software write wins over motion
  always_ff @(posedge clock) begin
    if (srst) begin
      position_reg <= '0;
    end else if (wrPos) begin
      position_reg <= regWdata;
    end else if (stepOk && !ctrlInterp) begin
      position_reg <= stepDir ? position_reg + stepInc
                              : position_reg - stepInc;
    end else if (unitMove) begin
      position_reg <= pendDir_reg ? position_reg + DATA_W'(1)
                                  : position_reg - DATA_W'(1);
    end
  end

  // microstep pulses toward the driver stage
  logic drvStep_reg, drvDir_reg;
  always_ff @(posedge clock) begin
    if (srst) begin
      drvStep_reg <= 1'b0;
      drvDir_reg  <= 1'b0;
    end else begin
      drvStep_reg <= (stepOk && !ctrlInterp) || unitMove;
      if (stepOk) begin
        drvDir_reg <= stepDir;
      end
    end
  end

  // quadrature decoder, x4; a double change is an error
  logic [1:0] encPrev_reg; // {b, a} of last cycle
  logic [1:0] encCur, encChg;
  logic       encUp, encErr;
  assign encCur = {encB, encA};
  assign encChg = encCur ^ encPrev_reg;
  assign encUp  = !(encPrev_reg[0] ^ encCur[1]);
  assign encErr = ctrlEnc && encChg == 2'b11;
  always_ff @(posedge clock) begin
    if (srst) begin
      encPrev_reg  <= '0;
      encCount_reg <= '0;
    end else begin
      encPrev_reg <= encCur;
      if (wrEnc) begin
        encCount_reg <= regWdata;
      end else if (ctrlEnc && (encChg == 2'b01 || encChg == 2'b10)) begin
        encCount_reg <= encUp ? encCount_reg + DATA_W'(1)
                              : encCount_reg - DATA_W'(1);
      end
    end
  end

  // converter handshake; a start while busy is ignored
  always_ff @(posedge clock) begin
    if (srst) begin
      adcStart_reg  <= 1'b0;
      adcBusy_reg   <= 1'b0;
      adcResult_reg <= '0;
    end else begin
      adcStart_reg <= wrAdc && !adcBusy_reg;
      if (adcDone) begin
        adcBusy_reg   <= 1'b0;
        adcResult_reg <= adcData;
      end else if (wrAdc) begin
        adcBusy_reg <= 1'b1;
      end
    end
  end

  // power-on sequence: drive one pad low, sense the other
  logic padOeN_reg;     // clk pad drive enable, low drives
  logic restoreReq_reg; // request to the settings store
  always_ff @(posedge clock) begin
    if (srst) begin
      boot_reg       <= BOOT_PADWAIT;
      settle_reg     <= '0;
      padOeN_reg     <= 1'b0;
      restoreReq_reg <= 1'b0;
      restored_reg   <= 1'b0;
    end else begin
      unique case (boot_reg)
        BOOT_PADWAIT: begin
          settle_reg <= settle_reg + 8'h01;
          if (settle_reg == 8'(PAD_SETTLE_CYC - 1)) begin
            padOeN_reg <= 1'b1;
            if (!padIn) begin
              boot_reg       <= BOOT_RESTORE;
              restoreReq_reg <= 1'b1;
            end else begin
              boot_reg <= BOOT_NORMAL;
            end
          end
        end
        BOOT_RESTORE: begin
          if (nvmRestoreDone) begin
            boot_reg       <= BOOT_NORMAL;
            restoreReq_reg <= 1'b0;
            restored_reg   <= 1'b1;
          end
        end
        BOOT_NORMAL: begin
          boot_reg <= BOOT_NORMAL;
        end
      endcase
    end
  end

  // led divider: one-cycle tick at each half period
  logic [31:0] ledCnt_reg;
  logic        ledPhase_reg;
  logic [31:0] halfCyc;
  logic        ledTick;
  assign halfCyc = (boot_reg == BOOT_RESTORE) ? 32'(FAST_HALF_CYC)
                                              : 32'(SLOW_HALF_CYC);
  assign ledTick = ledCnt_reg >= halfCyc - 32'h0000_0001;
  always_ff @(posedge clock) begin
    if (srst) begin
      ledCnt_reg   <= '0;
      ledPhase_reg <= 1'b0;
    end else if (ledTick) begin
      ledCnt_reg   <= '0;
      ledPhase_reg <= !ledPhase_reg;
    end else begin
      ledCnt_reg <= ledCnt_reg + 32'h0000_0001;
    end
  end

  // led pattern; restore outranks the firmware state
  logic green_reg, red_reg;
  always_ff @(posedge clock) begin
    if (srst) begin
      green_reg <= 1'b0;
      red_reg   <= 1'b0;
    end else if (boot_reg == BOOT_RESTORE) begin
      green_reg <= ledPhase_reg;
      red_reg   <= ledPhase_reg;
    end else if (boot_reg == BOOT_PADWAIT) begin
      green_reg <= 1'b0;
      red_reg   <= 1'b0;
    end else if (!fwValid || fwUpdate) begin
      green_reg <= 1'b1;
      red_reg   <= 1'b1;
    end else begin
      green_reg <= ledPhase_reg;
      red_reg   <= 1'b0;
    end
  end

  // interrupt events; a new event beats a clear in one cycle
  logic [IRQ_W-1:0] irqEv;
  assign irqEv[IRQ_LEFT]    = stepFire && !stepDir && leftBlock;
  assign irqEv[IRQ_RIGHT]   = stepFire && stepDir && rightBlock;
  assign irqEv[IRQ_ENC_ERR] = encErr;
  assign irqEv[IRQ_ADC]     = adcDone && adcBusy_reg;
  assign irqEv[IRQ_RESTORE] = boot_reg == BOOT_RESTORE && nvmRestoreDone;
  assign irqEv[IRQ_OVR]     = overrun;
  always_comb begin
    irqStat_next = irqStat_reg;
    if (wrClr) begin
      irqStat_next = irqStat_next & ~regWdata[IRQ_W-1:0];
    end
    irqStat_next = irqStat_next | irqEv;
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      irqStat_reg <= '0;
      irqEn_reg   <= '0;
      irq_reg     <= 1'b0;
    end else begin
      irqStat_reg <= irqStat_next;
      if (wrEn) begin
        irqEn_reg <= regWdata[IRQ_W-1:0];
      end
      irq_reg <= |(irqStat_next & (wrEn ? regWdata[IRQ_W-1:0] : irqEn_reg));
    end
  end

  // read mux; unmapped and write-only offsets read zero
  logic [DATA_W-1:0] statusWord;
  assign statusWord = DATA_W'({restored_reg, boot_reg != BOOT_NORMAL,
                               adcBusy_reg, rightBlock, leftBlock,
                               encB, encA, homeIn, rightIn, leftIn});
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_reg <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        OFS_CTRL:     rdata_reg <= DATA_W'(ctrl_reg);
        OFS_STATUS:   rdata_reg <= statusWord;
        OFS_POS:      rdata_reg <= position_reg;
        OFS_ENC:      rdata_reg <= encCount_reg;
        OFS_ADC:      rdata_reg <= DATA_W'(adcResult_reg);
        OFS_IRQ_STAT: rdata_reg <= DATA_W'(irqStat_reg);
        OFS_IRQ_EN:   rdata_reg <= DATA_W'(irqEn_reg);
        default:      rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  // outputs, each straight from a flop except the two pad data outputs, which are tied low
  assign regRdata           = rdata_reg;
  assign adcStart           = adcStart_reg;
  assign genPullupEn        = genPu_reg;
  assign homePullupEn       = homePu_reg;
  assign openDrainOutput    = 1'b0 & odOeN_reg;
  assign openDrainOutputOeN = odOeN_reg;
  assign padClkOut          = 1'b0 & padOeN_reg;
  assign padClkOeN          = padOeN_reg;
  assign nvmRestoreReq      = restoreReq_reg;
  assign drvStep            = drvStep_reg;
  assign drvDir             = drvDir_reg;
  assign position           = position_reg;
  assign greenLed           = green_reg;
  assign redLed             = red_reg;
  assign irq                = irq_reg;

  // checks
  AST_LEFT_BLOCK: assert property (
    (stepFire && !stepDir && leftBlock && pend_reg == '0 && !wrPos)
    |=> $stable(position_reg))
    else $error("motion toward left limit not blocked");
  AST_RIGHT_BLOCK: assert property (
    (stepFire && stepDir && rightBlock && pend_reg == '0 && !wrPos)
    |=> $stable(position_reg) && !drvStep_reg)
    else $error("motion toward right limit not blocked");
  // the done pulse must capture the converter word it came with
  AST_ADC_RESULT: assert property (
    adcDone |=> adcResult_reg == $past(adcData))
    else $error("conversion result not latched");
  AST_PULLUP_RESET: assert property (
    $past(srst) |=> genPullupEn)
    else $error("input pull-ups not on after reset");
  AST_HOME_PU: assert property (
    (wrCtrl && regWdata[CB_HOME_PU] == ctrl_reg[CB_HOME_PU])
    |=> ##1 $stable(homePullupEn))
    else $error("home pull-up changed by other control");
  AST_OD_DRIVE: assert property (
    ctrl_reg[CB_OD_ON] |=> !openDrainOutputOeN && !openDrainOutput)
    else $error("open-drain not driven low when active");
  AST_LED_NORMAL: assert property (
    (boot_reg == BOOT_NORMAL && fwValid && !fwUpdate)
    |=> !redLed && greenLed == $past(ledPhase_reg))
    else $error("normal led pattern wrong");
  AST_LED_NOFW: assert property (
    (boot_reg == BOOT_NORMAL && (!fwValid || fwUpdate))
    |=> redLed && greenLed)
    else $error("leds not both on without firmware");
  // once inside restore the divider never counts past the fast half
  AST_FAST_RATE: assert property (
    (boot_reg == BOOT_RESTORE && $past(boot_reg) == BOOT_RESTORE)
    |-> ledCnt_reg < 32'(FAST_HALF_CYC))
    else $error("restore flash rate not fast");
  AST_PAD_SHORT: assert property (
    (boot_reg == BOOT_PADWAIT && settle_reg == 8'(PAD_SETTLE_CYC - 1)
     && !padIn) |=> boot_reg == BOOT_RESTORE ##1 nvmRestoreReq)
    else $error("pad short did not start restore");
  AST_ENC_UP: assert property (
    (ctrlEnc && !wrEnc && encPrev_reg == 2'b00 && encCur == 2'b01)
    |=> encCount_reg == $past(encCount_reg) + DATA_W'(1))
    else $error("encoder forward count wrong");
  AST_DRV_STEP: assert property (
    (ctrlDrv && !ctrlInterp && stepOk && !wrPos) |=>
    position_reg == ($past(rightIn) ? $past(position_reg) + $past(stepInc)
                                    : $past(position_reg) - $past(stepInc)))
    else $error("driver step not applied");
  COV_RESTORE: cover property (
    boot_reg == BOOT_RESTORE ##[1:20] boot_reg == BOOT_NORMAL);
  COV_DRV_STEP: cover property (ctrlDrv && stepOk);
  COV_INTERP: cover property (stepOk && ctrlInterp ##1 unitMove[*3]);
  COV_IRQ: cover property ($rose(irq));
endmodule : mio_motion_io

// *** design/mio_pkg.sv ***
// shared constants and types for the motion i/o block
package mio_pkg;
  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ADC_W  = 12;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_POS      = 8'h08;
  localparam logic [7:0] OFS_ENC      = 8'h0c;
  localparam logic [7:0] OFS_ADC      = 8'h10;
  localparam logic [7:0] OFS_MOVE     = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h1c;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h20;

  // control register fields
  localparam int CB_LEFT_EN  = 0;
  localparam int CB_RIGHT_EN = 1;
  localparam int CB_GEN_PU   = 2;
  localparam int CB_HOME_PU  = 3;
  localparam int CB_OD_ON    = 4;
  localparam int CB_DRV_MODE = 5;
  localparam int CB_INTERP   = 6;
  localparam int CB_ENC_EN   = 7;
  localparam int CB_MS_LSB   = 8;
  localparam int MS_W        = 4;
  localparam int CTRL_W      = 12;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h084;
  localparam logic [MS_W-1:0]   MS_SHIFT_MAX = 4'h8;

  // move register fields
  localparam int MOVE_GO  = 0;
  localparam int MOVE_DIR = 1;

  // synchroniser lanes
  localparam int SY_LEFT  = 0;
  localparam int SY_RIGHT = 1;
  localparam int SY_HOME  = 2;
  localparam int SY_ENCA  = 3;
  localparam int SY_ENCB  = 4;
  localparam int SY_PAD   = 5;
  localparam int SYNC_W   = 6;

  // interrupt event bits
  localparam int IRQ_LEFT    = 0;
  localparam int IRQ_RIGHT   = 1;
  localparam int IRQ_ENC_ERR = 2;
  localparam int IRQ_ADC     = 3;
  localparam int IRQ_RESTORE = 4;
  localparam int IRQ_OVR     = 5;
  localparam int IRQ_W       = 6;

  // timing
  localparam int CLK_MHZ          = 200;
  localparam int PAD_SETTLE_NS    = 1000;
  localparam int PAD_SETTLE_CYC   = (PAD_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int LED_SLOW_HALF_MS = 500;
  localparam int LED_FAST_HALF_MS = 100;
  localparam int LED_SLOW_HALF_CYC = LED_SLOW_HALF_MS * CLK_MHZ * 1000;
  localparam int LED_FAST_HALF_CYC = LED_FAST_HALF_MS * CLK_MHZ * 1000;
  localparam int STEP_MAX_HZ      = 20000;

  // power-on sequence
  typedef enum logic [1:0] {
    BOOT_PADWAIT,
    BOOT_RESTORE,
    BOOT_NORMAL
  } mio_boot_t;
endpackage : mio_pkg

// *** design/mio_sync.sv ***
// two-flop synchroniser for all external input pins
`timescale 1ns/1ps
module mio_sync (
  input logic         clock,
  input logic         srst,
  mio_sync_if.sync_mp bus
);
  import mio_pkg::*;

  logic [SYNC_W-1:0] meta_reg;   // first stage, read only by second
  logic [SYNC_W-1:0] stable_reg; // second stage, safe to use

  // both stages clear to zero so pins read inactive right after reset
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_reg   <= '0;
      stable_reg <= '0;
    end else begin
      meta_reg   <= bus.rawIn;
      stable_reg <= meta_reg;
    end
  end

  assign bus.synced = stable_reg;
endmodule : mio_sync

// *** design/mio_sync_if.sv ***
// bundle between the pin synchroniser and its user
`timescale 1ns/1ps
interface mio_sync_if;
  logic [mio_pkg::SYNC_W-1:0] rawIn;  // pin levels, asynchronous
  logic [mio_pkg::SYNC_W-1:0] synced; // levels after two flops
  modport sync_mp (input rawIn, output synced);
  modport user_mp (output rawIn, input synced);
endinterface : mio_sync_if

// *** tb/mio_far_model.sv ***
// far-side model: converter, restore store, step/dir controller
`timescale 1ns/1ps
module mio_far_model (
  input  wire logic        clock,
  input  wire logic        adcStart,
  output logic [11:0]      adcData,
  output logic             adcDone,
  input  wire logic        nvmRestoreReq,
  output logic             nvmRestoreDone,
  input  wire logic        stepGo,
  input  wire logic        leftLvl,
  input  wire logic        rightLvl,
  output logic             stepPin,
  output logic             dirPin
);
  int adcCnt = 0;     // conversion time left
  int nvmCnt = 0;     // restore time left
  bit nvmSeen = 0;    // restore served once
  int gap = 10000;    // cycles since last step
  int pulse = 0;      // step high time left
  initial adcData = 12'h5a5;
  assign dirPin = rightLvl;
  // converter answers slowly; data is junk outside the done pulse
  always @(posedge clock) begin
    adcDone <= (adcCnt == 1);
    adcData <= (adcCnt == 1) ? 12'hfff : ~adcData;
    adcCnt <= adcStart ? 5 : (adcCnt > 0 ? adcCnt - 1 : 0);
    nvmRestoreDone <= (nvmCnt == 1);
    if (nvmRestoreReq && !nvmSeen) begin
      nvmSeen <= 1;
      nvmCnt <= 60;
    end else if (nvmCnt > 0) nvmCnt <= nvmCnt - 1;
    // steps refused closer than one 20 kHz period
    if (stepGo && gap >= 10000) begin
      pulse <= 4;
      gap <= 0;
    end else begin
      gap <= gap + 1;
      pulse <= pulse > 0 ? pulse - 1 : 0;
    end
    stepPin <= leftLvl | (pulse > 0);
  end
endmodule : mio_far_model

// *** tb/tb_mio_motion_io.sv ***
// self-checking bench for the motion i/o top
`timescale 1ns/1ps
module tb_mio_motion_io;
  import mio_pkg::*;
  logic clock = 0, srst = 1, regWr = 0, regRd = 0, stepGo = 0;
  logic leftLvl = 0, rightLvl = 0, home = 0, encA = 0, encB = 0;
  logic fwValid = 1, fwUpdate = 0, pad = 0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000, regRdata, v, pos;
  logic [11:0] adcData;
  logic stepPin, dirPin, adcStart, adcDone, nvmReq, nvmDone;
  logic genPu, homePu, odOeN, greenLed, redLed, irq, drvDir, padOeN;
  int badCount = 0, nTests = 0, i, c;
  always #2.5 clock = ~clock;
  mio_far_model i_mio_far_model (.clock(clock), .adcStart(adcStart),
    .adcData(adcData), .adcDone(adcDone), .nvmRestoreReq(nvmReq),
    .nvmRestoreDone(nvmDone), .stepGo(stepGo), .leftLvl(leftLvl),
    .rightLvl(rightLvl), .stepPin(stepPin), .dirPin(dirPin));
  mio_motion_io #(.SLOW_HALF_CYC(40), .FAST_HALF_CYC(8)) i_mio_motion_io (
    .clock(clock), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .stopLeftStepIn(stepPin), .stopRightDirIn(dirPin),
    .analogHomeInput(home), .generalInputAEnc(encA),
    .generalInputBEnc(encB), .adcStart(adcStart), .adcData(adcData),
    .adcDone(adcDone), .genPullupEn(genPu), .homePullupEn(homePu),
    .openDrainOutput(), .openDrainOutputOeN(odOeN), .padClkOut(),
    .padClkOeN(padOeN), .padDioIn(pad), .nvmRestoreReq(nvmReq),
    .nvmRestoreDone(nvmDone), .fwValid(fwValid), .fwUpdate(fwUpdate),
    .drvStep(), .drvDir(drvDir), .position(pos), .greenLed(greenLed),
    .redLed(redLed), .irq(irq));
  task automatic chk(input string nm, input logic [31:0] ex, got);
    nTests++;
    if (got !== ex) begin
      badCount++;
      $display("[FAIL] %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // bounded wait ran out: count it and stop
  task automatic lim(input bit ok, input string nm);
    if (!ok) begin
      chk(nm, 1, 0);
      conclude();
    end
  endtask : lim
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1;
    wt(1);
    regWr <= 0;
    wt(1);
  endtask : wr
  // read data only stands in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRd <= 1;
    wt(1);
    regRd <= 0;
    #1 v = regRdata;
    wt(1);
  endtask : rd
  task automatic edges(input int n);
    logic g;
    c = 0;
    g = greenLed;
    for (int k = 0; k < n; k++) begin
      wt(1);
      #1 c += (greenLed !== g);
      g = greenLed;
    end
    wt(1);
  endtask : edges
  task automatic step;
    stepGo <= 1;
    wt(1);
    stepGo <= 0;
    wt(20);
  endtask : step
  initial begin
    wt(2);
    srst <= 0;
    rd(OFS_CTRL); chk("ctrl reset", 32'h0000_0084, v);
    chk("gen pullup", 1, genPu);
    wr(OFS_IRQ_EN, 32'h0000_0010);
    for (i = 0; i < 400 && nvmReq !== 1'b1; i++) wt(1);
    lim(i < 400, "restore request");
    edges(30); chk("fast flash", 1, c >= 3);
    for (i = 0; i < 200 && nvmReq !== 1'b0; i++) wt(1);
    lim(i < 200, "restore end");
    wt(3); chk("restore irq", 1, irq);
    rd(OFS_STATUS); chk("restored", 1, v[9]);
    wr(OFS_IRQ_CLR, 32'h0000_0010); wt(2); chk("irq clr", 0, irq);
    edges(100); chk("slow flash", 1, c inside {[2:3]});
    chk("red off", 0, redLed);
    fwValid <= 0; wt(4); chk("no fw leds", 3, {redLed, greenLed});
    fwValid <= 1; fwUpdate <= 1; wt(4);
    chk("update leds", 3, {redLed, greenLed});
    fwUpdate <= 0;
    wr(OFS_CTRL, 32'h0000_009c); wt(2);
    chk("od on", 0, odOeN);
    chk("home pu", 1, homePu);
    chk("gen pu kept", 1, genPu);
    wr(OFS_CTRL, 32'h0000_0080); wt(2);
    chk("od off", 1, odOeN);
    chk("gen pu off", 0, genPu);
    // left limit held: only positive moves pass
    wr(OFS_CTRL, 32'h0000_0085); leftLvl <= 1; wt(4);
    wr(OFS_POS, 32'h0000_0100); wr(OFS_MOVE, 32'h0000_0001); wt(3);
    rd(OFS_POS); chk("left block", 32'h0000_0100, v);
    // one move is one microstep: a single unit at 256 per step
    wr(OFS_MOVE, 32'h0000_0003); wt(3);
    rd(OFS_POS); chk("left pass", 32'h0000_0101, v);
    wr(OFS_CTRL, 32'h0000_0086); leftLvl <= 0; rightLvl <= 1; wt(4);
    wr(OFS_MOVE, 32'h0000_0003); wt(3);
    rd(OFS_POS); chk("right block", 32'h0000_0101, v);
    wr(OFS_MOVE, 32'h0000_0001); wt(3);
    rd(OFS_POS); chk("right pass", 32'h0000_0100, v);
    // interpolator at quarter resolution; second move overruns it
    wr(OFS_CTRL, 32'h0000_02c4);
    wr(OFS_MOVE, 32'h0000_0003); wr(OFS_MOVE, 32'h0000_0003); wt(6);
    rd(OFS_POS); chk("interp up 4", 32'h0000_0104, v);
    rd(OFS_IRQ_STAT); chk("irq stat", 32'h0000_0023, v);
    // driver mode, quarter resolution then full
    wr(OFS_CTRL, 32'h0000_02a4); step();
    rd(OFS_POS); chk("step up 4", 32'h0000_0108, v);
    wr(OFS_CTRL, 32'h0000_00a4); rightLvl <= 0; wt(10001); step();
    rd(OFS_POS); chk("step dn 1", 32'h0000_0107, v);
    chk("pos out", 32'h0000_0107, pos);
    chk("dir out", 0, drvDir);
    wr(OFS_ADC, 32'h0000_0000); wt(20); home <= 1; wt(4);
    rd(OFS_ADC); chk("adc code", 32'h0000_0fff, v);
    rd(OFS_STATUS); chk("home level", 1, v[2]);
    wr(OFS_ENC, 32'h0000_0000);
    for (i = 0; i < 4; i++) begin
      {encB, encA} <= 2'(8'h2d >> (2 * i));
      wt(4);
    end
    rd(OFS_ENC); chk("enc count", 32'h0000_0004, v);
    rd(8'h7c); chk("unmapped", 32'h0000_0000, v);
    // second power-on with open pads: straight to normal, no restore
    pad <= 1; srst <= 1; wt(2); srst <= 0; wt(210);
    rd(OFS_STATUS); chk("no short", 0, v[9:8]);
    chk("no restore req", 0, nvmReq);
    chk("pad released", 1, padOeN);
    conclude();
  end
endmodule : tb_mio_motion_io
